// *** bench/card_host_reg_write_protect_assertions.sv ***
/*
 * Port checks for the card host write-protection bank.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`default_nettype none

module card_host_reg_write_protect_checker
    import wp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awready,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic rx_pop,
    input wire logic [31:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [PROT_COUNT-1:0][31:0] cfg_regs,
    input wire logic protect_on,
    input wire logic sw_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_b_hold;
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    property p_ar_block;
        rvalid |-> !arready;
    endproperty
    a_ar_block: assert property (p_ar_block)
        else $error("read address taken while answer open");
    property p_w_block;
        $rose(bvalid) |-> !awready && !wready;
    endproperty
    a_w_block: assert property (p_w_block)
        else $error("write channels ready during response");
    property p_pop_rvalid;
        rx_pop |-> $rose(rvalid);
    endproperty
    a_pop_rvalid: assert property (p_pop_rvalid)
        else $error("receive pop without read answer");
    property p_tx_hold;
        // Soft reset may drop a held word
        tx_valid && !tx_ready |=> sw_reset || (tx_valid && $stable(tx_data));
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("transmit word not held");
    property p_swrst_pulse;
        sw_reset |=> !sw_reset;
    endproperty
    a_swrst_pulse: assert property (p_swrst_pulse)
        else $error("soft reset longer than one cycle");
    property p_prot_change;
        $changed(protect_on) |-> $rose(bvalid);
    endproperty
    a_prot_change: assert property (p_prot_change)
        else $error("protection changed outside a write");
    property p_cfg_frozen;
        protect_on && $past(protect_on) && !sw_reset && !$past(sw_reset)
            |-> $stable(cfg_regs);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen)
        else $error("protected register changed");
endmodule : card_host_reg_write_protect_checker

bind card_host_reg_write_protect card_host_reg_write_protect_checker
    card_host_reg_write_protect_checker_inst (
    .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .arready(arready),
    .rdata(rdata), .rvalid(rvalid), .rready(rready), .rx_pop(rx_pop),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .cfg_regs(cfg_regs), .protect_on(protect_on), .sw_reset(sw_reset)
);

`default_nettype wire

// *** bench/card_host_reg_write_protect_tb.sv ***
/*
 * Self-checking bench for the card host write-protection bank.
 * Assumes the checker binds itself; bench drives bus and data paths.
 */
`default_nettype none

`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    miscompares++; $display("mismatch at %0t got %h exp %h", \
    $time, g, e); end end

module card_host_reg_write_protect_tb
    import wp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] rd;
        logic [1:0] resp;
    } row_t;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rx_data = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, rx_valid = 1'b0, tx_ready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rx_pop, tx_valid;
    logic sw_reset, protect_on, irq;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, tx_data, d;
    logic [PROT_COUNT-1:0][31:0] cfg_regs;
    int miscompares = 0, n_compared = 0, n_swrst = 0, n_pop = 0;
    row_t rows[10] = '{
        '{ADDR_HOST_MODE, 32'h0000_1101, 32'h0000_1101, RESP_OKAY},
        '{ADDR_DATA_TIMEOUT, 32'h0000_0072, 32'h0000_0072, RESP_OKAY},
        '{ADDR_CARD_SELECT, 32'h0000_00c3, 32'h0000_00c3, RESP_OKAY},
        '{ADDR_COMPL_TIMEOUT, 32'h0000_0044, 32'h0000_0044, RESP_OKAY},
        '{ADDR_DMA_CONFIG, 32'h0000_1105, 32'h0000_1105, RESP_OKAY},
        '{ADDR_HOST_CONFIG, 32'h0000_1016, 32'h0000_1016, RESP_OKAY},
        '{ADDR_WP_MODE, {WP_KEY, 8'h00}, 32'h0000_0000, RESP_OKAY},
        '{ADDR_WP_STATUS, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY},
        '{ADDR_IRQ_MASK, 32'h0000_0003, 32'h0000_0003, RESP_OKAY},
        '{32'hfff8_0300, 32'h0000_0001, 32'h0000_0000, RESP_SLVERR}};

    card_host_reg_write_protect card_host_reg_write_protect_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_pop(rx_pop),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .cfg_regs(cfg_regs), .protect_on(protect_on),
        .sw_reset(sw_reset), .irq(irq));

    always #4 aclk = ~aclk;

    always @(posedge aclk) begin
        if (sw_reset === 1'b1) n_swrst++;
        if (rx_pop === 1'b1) n_pop++;
    end

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Leading edge keeps bready and rready from two writes in one step
    task automatic wr(input logic [31:0] a, input logic [31:0] v,
                      input logic [3:0] s, output logic [1:0] rs);
        int t;
        t = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && t < 50);
        rs = bresp;
        bready <= 1'b0;
        if (t >= 50) miscompares++;
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        int t;
        t = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            t++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && t < 50);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (t >= 50) miscompares++;
    endtask : rd

    task automatic wo(input logic [31:0] a, input logic [31:0] v);
        logic [1:0] rs;
        wr(a, v, STRB_ALL, rs);
        `CHECK(rs, RESP_OKAY)
    endtask : wo

    task automatic rc(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        `CHECK(v, e)
    endtask : rc

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rc(ADDR_WP_STATUS, 32'h0000_0000);
        for (int i = 0; i < 10; i++) begin
            wr(rows[i].addr, rows[i].data, STRB_ALL, r);
            `CHECK(r, rows[i].resp)
            rd(rows[i].addr, d, r);
            `CHECK(d, rows[i].rd)
            `CHECK(r, rows[i].resp)
        end
        wo(ADDR_WP_MODE, {24'h4d_4348, 8'h01});
        `CHECK(protect_on, 1'b0)
        wr(ADDR_WP_MODE, {WP_KEY, 8'h01}, 4'h7, r);
        `CHECK(protect_on, 1'b0)
        wo(ADDR_WP_MODE, {WP_KEY, 8'h01});
        `CHECK(protect_on, 1'b1)
        rc(ADDR_WP_MODE, 32'h0000_0001);
        for (int i = 0; i < PROT_COUNT; i++) begin
            wo(rows[i].addr, 32'hdead_beef);
            `CHECK(cfg_regs[i], rows[i].data)
            `CHECK(irq, 1'b1)
            rc(ADDR_WP_STATUS, (32'(i + 1) << VSRC_LSB) | 32'h1);
            rc(ADDR_WP_STATUS, 32'h0000_0000);
            wo(ADDR_IRQ_STATUS, 32'h0000_0001);
            `CHECK(irq, 1'b0)
        end
        // Masked event still logs but keeps the line low
        wo(ADDR_IRQ_MASK, 32'h0000_0000);
        wo(ADDR_HOST_CONFIG, 32'h0000_0001);
        `CHECK(irq, 1'b0)
        rc(ADDR_IRQ_STATUS, 32'h0000_0001);
        wo(ADDR_IRQ_STATUS, 32'h0000_0001);
        rc(ADDR_IRQ_STATUS, 32'h0000_0000);
        wo(ADDR_IRQ_MASK, 32'h0000_0003);
        rc(ADDR_WP_STATUS, 32'h0000_0601);
        wo(ADDR_CTRL, 32'h1 << SWRST_BIT);
        `CHECK(irq, 1'b1)
        rc(ADDR_WP_STATUS, 32'h0000_0002);
        `CHECK(cfg_regs[5], 32'h0000_0000)
        wo(ADDR_DMA_CONFIG, 32'h0000_0001);
        wo(ADDR_CTRL, 32'h1 << SWRST_BIT);
        rc(ADDR_WP_STATUS, 32'h0000_0503);
        `CHECK(n_swrst, 2)
        wo(ADDR_IRQ_STATUS, 32'h0000_0003);
        `CHECK(irq, 1'b0)
        wo(ADDR_WP_MODE, {WP_KEY, 8'h00});
        `CHECK(protect_on, 1'b0)
        wo(ADDR_DATA_TIMEOUT, 32'h0000_0055);
        `CHECK(cfg_regs[1], 32'h0000_0055)
        wr(ADDR_DATA_TIMEOUT, 32'hffff_ffaa, 4'h1, r);
        `CHECK(r, RESP_OKAY)
        `CHECK(cfg_regs[1], 32'h0000_00aa)
        rc(ADDR_CTRL, 32'h0000_0000);
        rc(ADDR_WP_STATUS, 32'h0000_0000);
        rx_data <= 32'h0bad_cafe;
        rx_valid <= 1'b1;
        rc(ADDR_FIFO, 32'h0bad_cafe);
        rx_valid <= 1'b0;
        rc(ADDR_FIFO, 32'h0000_0000);
        `CHECK(n_pop, 1)
        wo(ADDR_FIFO, 32'h1234_abcd);
        `CHECK(tx_valid, 1'b1)
        `CHECK(tx_data, 32'h1234_abcd)
        wr(ADDR_FIFO, 32'h0000_0001, STRB_ALL, r);
        `CHECK(r, RESP_SLVERR)
        tx_ready <= 1'b1;
        repeat (2) @(posedge aclk);
        `CHECK(tx_valid, 1'b0)
        // Mid-run reset drops protection, log and interrupt
        wo(ADDR_WP_MODE, {WP_KEY, 8'h01});
        `CHECK(protect_on, 1'b1)
        wo(ADDR_HOST_MODE, 32'h0000_0001);
        `CHECK(cfg_regs[0], 32'h0000_0000)
        `CHECK(irq, 1'b1)
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        `CHECK(protect_on, 1'b0)
        `CHECK(irq, 1'b0)
        `CHECK(awready, 1'b0)
        rc(ADDR_WP_STATUS, 32'h0000_0000);
        wo(ADDR_HOST_MODE, 32'h0000_0001);
        `CHECK(cfg_regs[0], 32'h0000_0001)
        report_and_stop();
    end
endmodule : card_host_reg_write_protect_tb

`default_nettype wire

// *** inc/wp_pkg.sv ***
/*
 * Shared constants for the card host write-protection register bank:
 * register byte addresses, field positions, password, violation codes,
 * reset values and address decode helpers.
 * Assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
`default_nettype none

package wp_pkg;

    localparam int DATA_W = 32;
    localparam int PROT_COUNT = 6;
    localparam int IRQ_COUNT = 2;

    // Register byte addresses
    localparam logic [31:0] ADDR_CTRL = 32'hfff8_0000;
    localparam logic [31:0] ADDR_HOST_MODE = 32'hfff8_0004;
    localparam logic [31:0] ADDR_DATA_TIMEOUT = 32'hfff8_0008;
    localparam logic [31:0] ADDR_CARD_SELECT = 32'hfff8_000c;
    localparam logic [31:0] ADDR_COMPL_TIMEOUT = 32'hfff8_001c;
    localparam logic [31:0] ADDR_DMA_CONFIG = 32'hfff8_0050;
    localparam logic [31:0] ADDR_HOST_CONFIG = 32'hfff8_0054;
    localparam logic [31:0] ADDR_WP_MODE = 32'hfff8_00e4;
    localparam logic [31:0] ADDR_WP_STATUS = 32'hfff8_00e8;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'hfff8_0100;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hfff8_0104;
    localparam logic [31:0] ADDR_FIFO = 32'hfff8_0200;

    // Field positions
    localparam int SWRST_BIT = 7;
    localparam int WP_EN_BIT = 0;
    localparam int WP_KEY_LSB = 8;
    localparam int WP_KEY_MSB = 31;
    localparam int VTYPE_LSB = 0;
    localparam int VSRC_LSB = 8;
    localparam int IRQ_WRITE_BIT = 0;
    localparam int IRQ_SWRST_BIT = 1;

    localparam logic [23:0] WP_KEY = 24'h4d_4349;

    // Violation type codes, combined by OR
    localparam logic [3:0] VTYPE_NONE = 4'h0;
    localparam logic [3:0] VTYPE_WRITE = 4'h1;
    localparam logic [3:0] VTYPE_SWRST = 4'h2;
    localparam logic [15:0] VSRC_NONE = 16'h0000;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [3:0] STRB_ALL = 4'hf;
    localparam logic [2:0] SLOT_NONE = 3'h7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Slot of a protected register, SLOT_NONE if unprotected
    function automatic logic [2:0] prot_slot(input logic [31:0] addr);
        logic [2:0] slot;
        slot = SLOT_NONE;
        if (addr == ADDR_HOST_MODE) begin
            slot = 3'h0;
        end else if (addr == ADDR_DATA_TIMEOUT) begin
            slot = 3'h1;
        end else if (addr == ADDR_CARD_SELECT) begin
            slot = 3'h2;
        end else if (addr == ADDR_COMPL_TIMEOUT) begin
            slot = 3'h3;
        end else if (addr == ADDR_DMA_CONFIG) begin
            slot = 3'h4;
        end else if (addr == ADDR_HOST_CONFIG) begin
            slot = 3'h5;
        end
        return slot;
    endfunction : prot_slot

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                              input logic [31:0] wr,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

endpackage : wp_pkg

`default_nettype wire

// *** rtl/card_host_reg_write_protect.sv ***
/*
 * Write-protected configuration bank of a memory card host controller,
 * with its data aperture, reached as an AXI4-Lite slave.
 * Assumes the receive and transmit data paths run on aclk and use a
 * valid/ready style handshake; no signal here crosses a clock domain.
 */
`default_nettype none

// Behaviour
// R01 - A mode write with the right key sets or clears protection from bit 0.
// R02 - Mode writes whose key field is not 0x4D4349 change nothing.
// R03 - A blocked write to a protected register reports violation type 1.
// R04 - A soft reset while protected reports violation type 2.
// R05 - Both kinds since the last status read report violation type 3.
// R06 - Reading the status returns it and clears type and source to zero.
// R07 - The source field names the protected register that was targeted.
// R08 - The aperture reads the next received word and pushes written words.
// R09 - While protected, writes to the six registers leave them unchanged.
module card_host_reg_write_protect
    import wp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rx_data,
    input wire logic rx_valid,
    output logic rx_pop,
    output logic [31:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [PROT_COUNT-1:0][31:0] cfg_regs,
    output logic protect_on,
    output logic sw_reset,
    output logic irq
);

    typedef struct packed {
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic wp_en;
        logic [PROT_COUNT-1:0][31:0] regs;
        logic [31:0] tx_data;
        logic tx_valid;
        logic rx_pop;
        logic sw_reset;
    } bank_t;

    bank_t s_q;
    bank_t s_d;

    // Handshake between the bank and its violation log
    logic write_viol;
    logic [15:0] write_src;
    logic swrst_viol;
    logic status_read;
    logic [3:0] vtype;
    logic [15:0] vsrc;

    // Interrupt side
    logic irq_clear_we;
    logic irq_mask_we;
    logic [IRQ_COUNT-1:0] irq_events;
    logic [IRQ_COUNT-1:0] irq_status;
    logic [IRQ_COUNT-1:0] irq_mask;
    logic [IRQ_COUNT-1:0] mask_wr_bits;
    logic [31:0] mask_word;

    always_comb begin
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic [2:0] slot;
        logic [2:0] rslot;

        addr = s_q.aw_addr;
        data = s_q.w_data;
        strb = s_q.w_strb;
        slot = prot_slot(s_q.aw_addr);
        rslot = prot_slot(araddr);

        // Strobes fall back to zero each cycle; only the decode below
        // raises them, for exactly one cycle
        s_d = s_q;
        s_d.rx_pop = 1'b0;
        s_d.sw_reset = 1'b0;
        write_viol = 1'b0;
        write_src = VSRC_NONE;
        swrst_viol = 1'b0;
        status_read = 1'b0;
        irq_clear_we = 1'b0;
        irq_mask_we = 1'b0;

        // Holding word leaves at the edge the path takes it
        if (s_q.tx_valid && tx_ready) begin
            s_d.tx_valid = 1'b0;
        end

        // Address and data are taken in either order
        // and each is held until the write acts
        if (awvalid && s_q.awready) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_held = 1'b1;
            s_d.w_data = wdata;
            s_d.w_strb = wstrb;
        end
        // Response stays until the master takes it
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end

        // Write acts once both halves are held; waiting for bvalid to
        // clear keeps a second write from overtaking an unanswered one
        if (s_q.aw_held && s_q.w_held && !s_q.bvalid) begin
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            if (addr == ADDR_WP_MODE) begin
                // Key and enable live in different lanes, so a partial
                // write can never carry both
                if (strb == STRB_ALL &&
                    data[WP_KEY_MSB:WP_KEY_LSB] == WP_KEY) begin // R02
                    s_d.wp_en = data[WP_EN_BIT]; // R01
                end
            end else if (slot != SLOT_NONE) begin
                // Blocked write only logs; the stored word stays as it was
                if (s_q.wp_en) begin
                    write_viol = 1'b1; // R03 R09
                    write_src = 16'(slot) + 16'h0001; // R07
                end else begin
                    s_d.regs[slot] = merge_strb(s_q.regs[slot], data,
                                                strb);
                end
            end else if (addr == ADDR_CTRL) begin
                if (strb[0] && data[SWRST_BIT]) begin
                    // Reset goes ahead; protection only logs it
                    // Protection itself survives a soft reset
                    s_d.sw_reset = 1'b1;
                    s_d.tx_valid = 1'b0;
                    for (int i = 0; i < PROT_COUNT; i++) begin
                        s_d.regs[i] = REG_RESET;
                    end
                    swrst_viol = s_q.wp_en; // R04
                end
            end else if (addr == ADDR_FIFO) begin
                // One word of holding only; a push onto a word the
                // transmit path has not yet taken is refused
                if (s_q.tx_valid && !tx_ready) begin
                    s_d.bresp = RESP_SLVERR;
                end else begin
                    s_d.tx_data = data; // R08
                    s_d.tx_valid = 1'b1; // R08
                end
            end else if (addr == ADDR_IRQ_STATUS) begin
                irq_clear_we = 1'b1;
            end else if (addr == ADDR_IRQ_MASK) begin
                irq_mask_we = 1'b1;
            end else if (addr == ADDR_WP_STATUS) begin
                s_d.bresp = RESP_OKAY;
            end else begin
                s_d.bresp = RESP_SLVERR;
            end
        end

        // Readies drop while the answer is open: one write in flight
        s_d.awready = !s_d.aw_held && !s_d.bvalid;
        s_d.wready = !s_d.w_held && !s_d.bvalid;

        // Reads run beside writes; one read answer open at a time
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end

        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = REG_RESET;
            if (araddr == ADDR_WP_MODE) begin
                // Key never reads back
                s_d.rdata[WP_EN_BIT] = s_q.wp_en;
            end else if (araddr == ADDR_WP_STATUS) begin
                // Old value leaves now; the log clears at this same edge
                s_d.rdata[VTYPE_LSB +: 4] = vtype; // R06
                s_d.rdata[VSRC_LSB +: 16] = vsrc; // R06
                status_read = 1'b1; // R06
            end else if (rslot != SLOT_NONE) begin
                s_d.rdata = s_q.regs[rslot];
            end else if (araddr == ADDR_CTRL) begin
                s_d.rdata = REG_RESET;
            end else if (araddr == ADDR_FIFO) begin
                // Empty receive side reads as zero
                // and pops nothing
                if (rx_valid) begin
                    s_d.rdata = rx_data; // R08
                    s_d.rx_pop = 1'b1; // R08
                end
            end else if (araddr == ADDR_IRQ_STATUS) begin
                s_d.rdata[IRQ_COUNT-1:0] = irq_status;
            end else if (araddr == ADDR_IRQ_MASK) begin
                s_d.rdata[IRQ_COUNT-1:0] = irq_mask;
            end else begin
                s_d.rresp = RESP_SLVERR;
            end
        end

        // Address ready only while no read answer is waiting
        s_d.arready = !s_d.rvalid;
    end

    // Synchronous reset clears the whole state at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Sticky violation log, cleared by a status read
    wp_status_log u_log (
        .aclk(aclk),
        .aresetn(aresetn),
        .write_viol(write_viol),
        .write_src(write_src),
        .swrst_viol(swrst_viol),
        .read_clear(status_read),
        .vtype(vtype),
        .vsrc(vsrc)
    );

    always_comb begin
        irq_events = '0;
        irq_events[IRQ_WRITE_BIT] = write_viol;
        irq_events[IRQ_SWRST_BIT] = swrst_viol;
        // Mask takes byte lanes like the protected registers
        mask_word = REG_RESET;
        mask_word[IRQ_COUNT-1:0] = irq_mask;
        mask_word = merge_strb(mask_word, s_q.w_data, s_q.w_strb);
        mask_wr_bits = mask_word[IRQ_COUNT-1:0];
    end

    // Two event bits: blocked write and protected soft reset
    irq_sticky #(
        .N(IRQ_COUNT)
    ) u_irq (
        .aclk(aclk),
        .aresetn(aresetn),
        .events(irq_events),
        .clear_we(irq_clear_we),
        .clear_bits(s_q.w_data[IRQ_COUNT-1:0]),
        .mask_we(irq_mask_we),
        .mask_bits(mask_wr_bits),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // Outputs straight from the state register
    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rresp = s_q.rresp;
    assign rdata = s_q.rdata;
    assign rx_pop = s_q.rx_pop;
    assign tx_data = s_q.tx_data;
    assign tx_valid = s_q.tx_valid;
    assign cfg_regs = s_q.regs;
    assign protect_on = s_q.wp_en;
    assign sw_reset = s_q.sw_reset;

endmodule : card_host_reg_write_protect

`default_nettype wire

// *** rtl/irq_sticky.sv ***
/*
 * Sticky interrupt status with write-one-to-clear, a mask register and
 * one level interrupt output.
 * Assumes event pulses and write strobes on the same clock.
 */
`default_nettype none

module irq_sticky
    import wp_pkg::*;
#(
    parameter int N = IRQ_COUNT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [N-1:0] events,
    input wire logic clear_we,
    input wire logic [N-1:0] clear_bits,
    input wire logic mask_we,
    input wire logic [N-1:0] mask_bits,
    output logic [N-1:0] status,
    output logic [N-1:0] mask,
    output logic irq
);

    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] mask;
        logic irq;
    } irq_t;

    irq_t s_q;
    irq_t s_d;

    always_comb begin
        s_d = s_q;
        if (clear_we) begin
            s_d.status = s_d.status & ~clear_bits;
        end
        // New events win over a clear in the same cycle
        s_d.status = s_d.status | events;
        if (mask_we) begin
            s_d.mask = mask_bits;
        end
        s_d.irq = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign status = s_q.status;
    assign mask = s_q.mask;
    assign irq = s_q.irq;

endmodule : irq_sticky

`default_nettype wire

// *** rtl/wp_status_log.sv ***
/*
 * Violation log behind the write-protection status register.
 * Assumes single-cycle event pulses and a read-clear pulse from the
 * register bank on the same clock.
 */
`default_nettype none

module wp_status_log
    import wp_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic write_viol,
    input wire logic [15:0] write_src,
    input wire logic swrst_viol,
    input wire logic read_clear,
    output logic [3:0] vtype,
    output logic [15:0] vsrc
);

    typedef struct packed {
        logic [3:0] vtype;
        logic [15:0] vsrc;
    } log_t;

    log_t s_q;
    log_t s_d;

    always_comb begin
        s_d = s_q;
        if (read_clear) begin
            s_d.vtype = VTYPE_NONE; // R06
            s_d.vsrc = VSRC_NONE; // R06
        end
        // Set after clear: an event in the read cycle survives
        if (write_viol) begin
            s_d.vtype = s_d.vtype | VTYPE_WRITE; // R03 R05
            s_d.vsrc = write_src; // R07
        end
        if (swrst_viol) begin
            s_d.vtype = s_d.vtype | VTYPE_SWRST; // R04 R05
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign vtype = s_q.vtype;
    assign vsrc = s_q.vsrc;

endmodule : wp_status_log

`default_nettype wire
